// File: gsw_pkg.sv
// Package for the gauge status-word readout: addresses, command codes, field positions and reset values.
package gsw_pkg;
  localparam logic [6:0]  GSW_SLAVE_ADDR      = 7'h47;
  localparam logic [7:0]  GSW_CMD_STATUS_READ = 8'h01;
  localparam logic [7:0]  GSW_CMD_CONFIG_WR   = 8'h02;
  localparam logic [7:0]  GSW_CMD_RESET       = 8'h00;
  localparam int          GSW_ST_DISCH_OC     = 7;
  localparam int          GSW_ST_CHG_OC       = 6;
  localparam int          GSW_ST_COMPARE      = 5;
  localparam int          GSW_ST_CNT_SEL      = 4;
  localparam int          GSW_ST_SOFT_OFF     = 3;
  localparam int          GSW_ST_DIRECTION    = 2;
  localparam int          GSW_ST_DIR_CHANGE   = 1;
  localparam logic [15:0] GSW_ST_ONES_MASK    = 16'hff01;
  localparam int          GSW_CFG_SOFT_OFF    = 9;
  localparam int          GSW_CFG_CLR_INT     = 7;
  localparam int          GSW_CFG_CNT_SEL     = 6;
  localparam logic [15:0] GSW_CFG_RESET       = 16'h0000;
  typedef enum logic [2:0] {
    GSW_IDLE, GSW_ADDR, GSW_ADDR_ACK, GSW_WR, GSW_WR_ACK, GSW_RD, GSW_RD_ACK, GSW_IGNORE
  } gsw_state_t;
endpackage

// File: gsw_sync.sv
// Two-flop synchroniser for one pin input.
`timescale 1ns/100ps
`default_nettype none
module gsw_sync
  import gsw_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic async_in,
  output logic      sync_out
);
  logic [1:0] sync_ff;
  always_ff @(posedge mclk) begin
    if (reset) begin
      sync_ff <= 2'h3;
    end else begin
      sync_ff <= {sync_ff[0], async_in};
    end
  end
  assign sync_out = sync_ff[1];
endmodule
`default_nettype wire

// File: gsw_edge.sv
// Edge and bus-condition detector for the synchronised serial clock and data.
`timescale 1ns/100ps
`default_nettype none
module gsw_edge
  import gsw_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_seen,
  output logic      stop_seen
);
  logic scl_d_ff;
  logic sda_d_ff;
  always_ff @(posedge mclk) begin
    if (reset) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl;
      sda_d_ff <= sda;
    end
  end
  assign scl_rise   = scl & ~scl_d_ff;
  assign scl_fall   = ~scl & scl_d_ff;
  assign start_seen = scl & scl_d_ff & sda_d_ff & ~sda;
  assign stop_seen  = scl & scl_d_ff & ~sda_d_ff & sda;
endmodule
`default_nettype wire

// File: gsw_top.sv
// Status-word readout of the fuel-gauge serial slave.
// Contract
// - Status by read-word or receive-byte.
// - Received command code latched until replaced.
// - Receive-byte after status command returns low byte.
// - Bits 15..8 and 0 read one.
// - Bit 7 sets on discharge overcurrent.
// - Bit 6 sets on charge overcurrent.
// - Overcurrent flags clear: soft-off, reset, clear-bit.
// - Bit 5 compare flag, same clears.
// - Bit 4 mirrors counter-select bit.
// - Bit 3 shows soft-off mode.
// - Bit 2 charge one, discharge zero.
// - Bit 1 sets on direction change.
// - Direction flag clears: reset, clear, soft-off write.
// - Config bit 7 write clears four flags.
// - Config bit 9 selects soft-off mode.
// - Config bit 6 selects charge counter.
// - Respond only to address 1000111.
`timescale 1ns/100ps
`default_nettype none
module gsw_top
  import gsw_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic disch_overcurrent,
  input  wire logic chg_overcurrent,
  input  wire logic compare_interrupt,
  input  wire logic charge_detect,
  input  wire logic discharge_detect,
  output logic      soft_off_mode,
  output logic      counter_select,
  output logic      clear_counters,
  output logic [15:0] config_word
);
  typedef struct packed {
    gsw_state_t  state;
    logic [3:0]  bit_cnt;
    logic [7:0]  shift;
    logic        is_read;
    logic        byte_idx;
    logic        got_cmd;
    logic [7:0]  cmd;
    logic [15:0] snap;
    logic [7:0]  data_lo;
    logic [15:0] cfg;
    logic        clr_cnt;
    logic        disch_oc;
    logic        chg_oc;
    logic        cmp;
    logic        dir;
    logic        dir_chg;
    logic        sda_low;
  } gsw_regs_t;

  gsw_regs_t r_ff;
  gsw_regs_t nxt_r;
  logic scl_s, sda_s, scl_rise, scl_fall, start_seen, stop_seen;
  logic [15:0] status_now;
  logic clr_int_wr, soft_wr, cfg_wr;
  logic [15:0] read_word;

  gsw_sync u_sync_scl (.mclk(mclk), .reset(reset), .async_in(scl_in), .sync_out(scl_s));
  gsw_sync u_sync_sda (.mclk(mclk), .reset(reset), .async_in(sda_in), .sync_out(sda_s));
  gsw_edge u_edge (.mclk(mclk), .reset(reset), .scl(scl_s), .sda(sda_s), .scl_rise(scl_rise),
                   .scl_fall(scl_fall), .start_seen(start_seen), .stop_seen(stop_seen));

  always_comb begin
    status_now = GSW_ST_ONES_MASK;
    status_now[GSW_ST_DISCH_OC]   = r_ff.disch_oc;
    status_now[GSW_ST_CHG_OC]     = r_ff.chg_oc;
    status_now[GSW_ST_COMPARE]    = r_ff.cmp;
    status_now[GSW_ST_CNT_SEL]    = r_ff.cfg[GSW_CFG_CNT_SEL];
    status_now[GSW_ST_SOFT_OFF]   = r_ff.cfg[GSW_CFG_SOFT_OFF];
    status_now[GSW_ST_DIRECTION]  = r_ff.dir;
    status_now[GSW_ST_DIR_CHANGE] = r_ff.dir_chg;
  end

  // A configuration write takes effect on the clock fall that ends the eighth bit of its second data byte, before that byte is acknowledged.
  assign cfg_wr     = (r_ff.state == GSW_WR) && scl_fall && (r_ff.bit_cnt == 4'h7) && r_ff.got_cmd
                      && r_ff.byte_idx && (r_ff.cmd == GSW_CMD_CONFIG_WR);
  assign clr_int_wr = cfg_wr && r_ff.data_lo[GSW_CFG_CLR_INT];
  assign soft_wr    = cfg_wr && r_ff.shift[GSW_CFG_SOFT_OFF - 8];
  // A read with any other command latched sends all ones.
  assign read_word  = (r_ff.cmd == GSW_CMD_STATUS_READ) ? status_now : 16'hffff;

  always_comb begin
    nxt_r = r_ff;
    nxt_r.clr_cnt = 1'b0;
    case (r_ff.state)
      GSW_IDLE, GSW_IGNORE: begin
      end
      GSW_ADDR: begin
        // Bits are counted on rising edges, so the falling edge that ends a start is not taken as a bit.
        if (scl_rise) begin
          nxt_r.shift   = {r_ff.shift[6:0], sda_s};
          nxt_r.bit_cnt = r_ff.bit_cnt + 4'h1;
        end
        if (scl_fall && r_ff.bit_cnt == 4'h8) begin
          if (r_ff.shift[7:1] == GSW_SLAVE_ADDR) begin
            nxt_r.state   = GSW_ADDR_ACK;
            nxt_r.is_read = r_ff.shift[0];
            nxt_r.sda_low = 1'b1;
            nxt_r.byte_idx = 1'b0;
            nxt_r.got_cmd = 1'b0;
          end else begin
            nxt_r.state = GSW_IGNORE;
          end
        end
      end
      GSW_ADDR_ACK: begin
        if (scl_fall) begin
          nxt_r.bit_cnt = 4'h0;
          if (r_ff.is_read) begin
            // Receive-byte after a status command yields the low byte only; read-word yields both.
            nxt_r.snap    = read_word;
            nxt_r.state   = GSW_RD;
            nxt_r.shift   = read_word[7:0];
            nxt_r.sda_low = ~read_word[7];
          end else begin
            nxt_r.state   = GSW_WR;
            nxt_r.sda_low = 1'b0;
          end
        end
      end
      GSW_WR: begin
        if (scl_rise) begin
          nxt_r.shift = {r_ff.shift[6:0], sda_s};
        end
        if (scl_fall && r_ff.bit_cnt == 4'h7) begin
          nxt_r.state   = GSW_WR_ACK;
          nxt_r.sda_low = 1'b1;
          if (!r_ff.got_cmd) begin
            nxt_r.cmd     = r_ff.shift;
            nxt_r.got_cmd = 1'b1;
          end else if (!r_ff.byte_idx) begin
            nxt_r.data_lo  = r_ff.shift;
            nxt_r.byte_idx = 1'b1;
          end else if (r_ff.cmd == GSW_CMD_CONFIG_WR) begin
            nxt_r.cfg     = {r_ff.shift, r_ff.data_lo};
            nxt_r.clr_cnt = r_ff.shift[0];
            nxt_r.cfg[GSW_CFG_CLR_INT] = 1'b0;
            nxt_r.byte_idx = 1'b0;
          end
        end else if (scl_fall) begin
          nxt_r.bit_cnt = r_ff.bit_cnt + 4'h1;
        end
      end
      GSW_WR_ACK: begin
        if (scl_fall) begin
          nxt_r.state   = GSW_WR;
          nxt_r.sda_low = 1'b0;
          nxt_r.bit_cnt = 4'h0;
        end
      end
      GSW_RD: begin
        if (scl_fall) begin
          if (r_ff.bit_cnt == 4'h7) begin
            nxt_r.state   = GSW_RD_ACK;
            nxt_r.sda_low = 1'b0;
          end else begin
            nxt_r.bit_cnt = r_ff.bit_cnt + 4'h1;
            nxt_r.shift   = {r_ff.shift[6:0], 1'b1};
            nxt_r.sda_low = ~r_ff.shift[6];
          end
        end
      end
      GSW_RD_ACK: begin
        if (scl_rise && sda_s) begin
          nxt_r.state = GSW_IGNORE;
        end else if (scl_fall) begin
          nxt_r.state   = GSW_RD;
          nxt_r.bit_cnt = 4'h0;
          nxt_r.shift    = r_ff.snap[15:8];
          nxt_r.byte_idx = 1'b1;
          nxt_r.sda_low  = ~r_ff.snap[15];
        end
      end
      default: begin
        nxt_r.state = GSW_IDLE;
      end
    endcase
    if (start_seen) begin
      nxt_r.state   = GSW_ADDR;
      nxt_r.bit_cnt = 4'h0;
      nxt_r.sda_low = 1'b0;
    end else if (stop_seen) begin
      nxt_r.state   = GSW_IDLE;
      nxt_r.sda_low = 1'b0;
    end

    // Clears come first so that a same-cycle event still sets its flag, except an overcurrent or compare event in soft-off.
    if (r_ff.cfg[GSW_CFG_SOFT_OFF] || clr_int_wr) begin
      nxt_r.disch_oc = 1'b0;
      nxt_r.chg_oc   = 1'b0;
      nxt_r.cmp      = 1'b0;
    end
    if (clr_int_wr || soft_wr) begin
      nxt_r.dir_chg = 1'b0;
    end
    if (!r_ff.cfg[GSW_CFG_SOFT_OFF]) begin
      // Detectors are idle in soft-off, so events are not taken there.
      if (disch_overcurrent) nxt_r.disch_oc = 1'b1;
      if (chg_overcurrent)   nxt_r.chg_oc   = 1'b1;
      if (compare_interrupt) nxt_r.cmp      = 1'b1;
    end
    if (charge_detect && !r_ff.dir) begin
      nxt_r.dir     = 1'b1;
      nxt_r.dir_chg = 1'b1;
    end else if (discharge_detect && !charge_detect && r_ff.dir) begin
      nxt_r.dir     = 1'b0;
      nxt_r.dir_chg = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      r_ff <= '{state: GSW_IDLE, cmd: GSW_CMD_RESET, cfg: GSW_CFG_RESET, snap: GSW_ST_ONES_MASK,
                data_lo: 8'hff, default: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign sda_out        = 1'b0;
  assign sda_oe         = r_ff.sda_low;
  assign soft_off_mode  = r_ff.cfg[GSW_CFG_SOFT_OFF];
  assign counter_select = r_ff.cfg[GSW_CFG_CNT_SEL];
  assign clear_counters = r_ff.clr_cnt;
  assign config_word    = r_ff.cfg;

  property p_ones;
    @(posedge mclk) disable iff (reset) (status_now | ~GSW_ST_ONES_MASK) == 16'hffff;
  endproperty
  a_ones: assert property (p_ones) else $error("unused status bits not one");
  property p_disch;
    @(posedge mclk) disable iff (reset)
      disch_overcurrent && !r_ff.cfg[GSW_CFG_SOFT_OFF] |=> status_now[GSW_ST_DISCH_OC];
  endproperty
  a_disch: assert property (p_disch) else $error("discharge flag missed");
  property p_chg;
    @(posedge mclk) disable iff (reset)
      chg_overcurrent && !r_ff.cfg[GSW_CFG_SOFT_OFF] |=> status_now[GSW_ST_CHG_OC];
  endproperty
  a_chg: assert property (p_chg) else $error("charge flag missed");
  property p_softclr;
    @(posedge mclk) disable iff (reset)
      r_ff.cfg[GSW_CFG_SOFT_OFF] ##1 r_ff.cfg[GSW_CFG_SOFT_OFF] |-> !r_ff.disch_oc && !r_ff.chg_oc && !r_ff.cmp;
  endproperty
  a_softclr: assert property (p_softclr) else $error("flags not cleared in soft-off");
  property p_clear_interrupts_bit;
    @(posedge mclk) disable iff (reset)
      clr_int_wr && !disch_overcurrent && !chg_overcurrent && !compare_interrupt |=> !r_ff.cmp && !r_ff.chg_oc;
  endproperty
  a_clear_interrupts_bit: assert property (p_clear_interrupts_bit) else $error("clear-interrupt write ignored");
  property p_mirror;
    @(posedge mclk) disable iff (reset) status_now[GSW_ST_CNT_SEL] == counter_select;
  endproperty
  a_mirror: assert property (p_mirror) else $error("select mirror wrong");
  property p_dir;
    @(posedge mclk) disable iff (reset) charge_detect |=> status_now[GSW_ST_DIRECTION];
  endproperty
  a_dir: assert property (p_dir) else $error("direction not charge");
  property p_dirchg;
    @(posedge mclk) disable iff (reset) $changed(r_ff.dir) |-> r_ff.dir_chg;
  endproperty
  a_dirchg: assert property (p_dirchg) else $error("direction change not flagged");
  property p_snap;
    @(posedge mclk) disable iff (reset)
      r_ff.state == GSW_RD && $past(r_ff.state) == GSW_RD |-> $stable(r_ff.snap);
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot moved during read");
  property p_rdbit;
    @(posedge mclk) disable iff (reset)
      r_ff.state == GSW_RD |-> sda_oe == ~r_ff.snap[{r_ff.byte_idx, 3'h7 - r_ff.bit_cnt[2:0]}];
  endproperty
  a_rdbit: assert property (p_rdbit) else $error("read bit not from snapshot");
  property p_foreign;
    @(posedge mclk) disable iff (reset)
      r_ff.state == GSW_ADDR && scl_fall && r_ff.bit_cnt == 4'h8 && r_ff.shift[7:1] != GSW_SLAVE_ADDR
      |=> r_ff.state == GSW_IGNORE && !sda_oe;
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign address answered");
  property p_latch;
    @(posedge mclk) disable iff (reset)
      $changed(r_ff.cmd) |-> $past(r_ff.state) == GSW_WR && !$past(r_ff.got_cmd);
  endproperty
  a_latch: assert property (p_latch) else $error("command code changed outside a command byte");
  property p_cmp;
    @(posedge mclk) disable iff (reset)
      compare_interrupt && !r_ff.cfg[GSW_CFG_SOFT_OFF] |=> status_now[GSW_ST_COMPARE];
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare flag missed");
  property p_dis;
    @(posedge mclk) disable iff (reset)
      discharge_detect && !charge_detect |=> !status_now[GSW_ST_DIRECTION];
  endproperty
  a_dis: assert property (p_dis) else $error("direction not discharge");
  c_cfg:  cover property (@(posedge mclk) cfg_wr);
  c_ignore: cover property (@(posedge mclk) r_ff.state == GSW_IGNORE);
  c_read: cover property (@(posedge mclk) r_ff.state == GSW_RD_ACK);
  c_soft: cover property (@(posedge mclk) soft_wr);
endmodule
`default_nettype wire

// File: gsw_host.sv
// Serial host model that clocks the link and pulls the open-drain data line.
`timescale 1ns/100ps
`default_nettype none
module gsw_host (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // The link clock idles high and only runs inside frames.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic q(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Data moves only while the clock is low; one bit is 8 cycles, 80 ns.
  task automatic bit_io(input logic b, output logic r);
    sda_low <= ~b;
    q(3);
    scl <= 1'b1;
    q(2);
    r = sda;
    q(1);
    scl <= 1'b0;
    q(2);
  endtask
  // Also serves as a repeated start, since the clock is raised with data high.
  task automatic start();
    sda_low <= 1'b0;
    q(2);
    scl <= 1'b1;
    q(4);
    sda_low <= 1'b1;
    q(4);
    scl <= 1'b0;
    q(2);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    q(3);
    scl <= 1'b1;
    q(4);
    sda_low <= 1'b0;
    q(4);
  endtask
  task automatic wr(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, nak);
  endtask
  // The last byte of a read is refused so that the device lets go of the line.
  task automatic rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

// File: gsw_top_tb_top.sv
// Self-checking bench for the status-word readout with a random event mix.
`timescale 1ns/100ps
`default_nettype none
module gsw_top_tb_top
  import gsw_pkg::*;
;
  logic        mclk, reset, scl, sda_low, sda_out, sda_oe;
  logic        od, oc, cmp, chg, dis, soft_off_mode, counter_select, clear_counters;
  logic [15:0] config_word, w;
  logic [7:0]  b;
  logic        nak;
  logic        e_od, e_oc, e_cmp, e_cs, e_so, e_dir, e_dc;
  int          num_errors, samples_checked;
  int          clr_seen = 0;
  // The line has a pull-up, so it reads high whenever nobody pulls it down.
  wire logic   sda = ~(sda_low | (sda_oe & ~sda_out));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Counts clear-counter pulses, which stand for a single cycle only.
  always @(posedge mclk) begin
    if (clear_counters === 1'b1) begin
      clr_seen <= clr_seen + 1;
    end
  end

  gsw_top i_gsw_top (.mclk(mclk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .disch_overcurrent(od), .chg_overcurrent(oc), .compare_interrupt(cmp),
    .charge_detect(chg), .discharge_detect(dis), .soft_off_mode(soft_off_mode),
    .counter_select(counter_select), .clear_counters(clear_counters), .config_word(config_word));
  gsw_host i_gsw_host (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));

  function automatic logic [15:0] exp_status();
    return {8'hff, e_od, e_oc, e_cmp, e_cs, e_so, e_dir, e_dc, 1'b1};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask
  task automatic results();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic addr(input logic rd);
    i_gsw_host.wr({GSW_SLAVE_ADDR, rd}, nak);
    chk("address ack", 16'h0000, {15'h0000, nak});
  endtask
  task automatic rd_word(output logic [15:0] d);
    i_gsw_host.start();
    addr(1'b0);
    i_gsw_host.wr(GSW_CMD_STATUS_READ, nak);
    i_gsw_host.start();
    addr(1'b1);
    i_gsw_host.rd(1'b0, d[7:0]);
    i_gsw_host.rd(1'b1, d[15:8]);
    i_gsw_host.stop();
  endtask
  task automatic rx_byte(output logic [7:0] d);
    i_gsw_host.start();
    addr(1'b1);
    i_gsw_host.rd(1'b1, d);
    i_gsw_host.stop();
  endtask
  task automatic cfg(input logic [15:0] v);
    int c0;
    c0 = clr_seen;
    i_gsw_host.start();
    addr(1'b0);
    i_gsw_host.wr(GSW_CMD_CONFIG_WR, nak);
    i_gsw_host.wr(v[7:0], nak);
    i_gsw_host.wr(v[15:8], nak);
    i_gsw_host.stop();
    e_cs = v[GSW_CFG_CNT_SEL];
    e_so = v[GSW_CFG_SOFT_OFF];
    if (v[GSW_CFG_CLR_INT] | e_so) begin
      {e_od, e_oc, e_cmp, e_dc} = '0;
    end
    chk("config_word", v & ~16'h0080, config_word);
    chk("mode outputs", {14'h0, e_so, e_cs}, {14'h0, soft_off_mode, counter_select});
    chk("clear pulses", {15'h0000, v[8]}, 16'(clr_seen - c0));
  endtask
  // Direction code 1 is charging, 2 discharging, anything else no current seen.
  task automatic ev(input logic [2:0] m, input logic [1:0] d);
    od <= m[2];
    oc <= m[1];
    cmp <= m[0];
    chg <= (d == 2'd1);
    dis <= (d == 2'd2);
    @(posedge mclk);
    {od, oc, cmp, chg, dis} <= '0;
    repeat (3) @(posedge mclk);
    {e_od, e_oc, e_cmp} = {e_od, e_oc, e_cmp} | m;
    if (d == 2'd1) begin
      e_dc |= ~e_dir;
      e_dir = 1'b1;
    end
    if (d == 2'd2) begin
      e_dc |= e_dir;
      e_dir = 1'b0;
    end
  endtask

  initial begin
    reset = 1'b1;
    {od, oc, cmp, chg, dis} = '0;
    {e_od, e_oc, e_cmp, e_cs, e_so, e_dir, e_dc} = '0;
    num_errors = 0;
    samples_checked = 0;
    void'($urandom(98));
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("config reset", GSW_CFG_RESET, config_word);
    rd_word(w);
    chk("status reset", exp_status(), w);
    for (int i = 0; i < 6; i++) begin
      ev(3'($urandom), 2'($urandom));
      rd_word(w);
      chk("status word", exp_status(), w);
      rx_byte(b);
      w = exp_status();
      chk("receive byte", {8'h00, w[7:0]}, {8'h00, b});
      cfg({7'h00, 1'($urandom), 1'(i % 2), 1'($urandom), 6'h00});
      rd_word(w);
      chk("status after config", exp_status(), w);
    end
    ev(3'h7, 2'd1);
    cfg(16'h0200);
    rx_byte(b);
    chk("receive after config", 16'h00ff, {8'h00, b});
    rd_word(w);
    chk("soft off status", exp_status(), w);
    cfg(16'h0000);
    rd_word(w);
    chk("resumed status", exp_status(), w);
    i_gsw_host.start();
    i_gsw_host.wr({GSW_SLAVE_ADDR ^ 7'h01, 1'b1}, nak);
    i_gsw_host.stop();
    chk("foreign address", 16'h0001, {15'h0000, nak});
    results();
  end

  initial begin
    repeat (100000) @(posedge mclk);
    num_errors++;
    results();
  end
endmodule
`default_nettype wire
